// [hw/fpad_pkg.sv]
// Package for the floating abs/add/flag-copy datapath slice.
// Assumes a single clock domain; consumers reference items as fpad_pkg::name.
package fpad_pkg;
  // Operation select codes presented by the processor
  typedef enum logic [1:0]
  {
    OP_ABS  = 2'h0,
    OP_ADD  = 2'h1,
    OP_COPY = 2'h2,
    OP_NONE = 2'h3
  } fpad_op_t;

  // Operand word layout: sign, 8-bit biased exponent, 55-bit stored fraction
  localparam int WORD_W     = 64;
  localparam int SIGN_POS   = 63;
  localparam int EXP_MSB    = 62;
  localparam int EXP_LSB    = 55;
  localparam int EXP_W      = 8;
  localparam int FRAC_W     = 55;
  localparam int SGL_FRAC_W = 23;
  // Significand with hidden bit, plus two guard bits
  localparam int MANT_W     = 56;
  localparam int GUARD_W    = 2;
  // Exponent bias and the wrap offset of an out-of-range exponent (octal 400)
  localparam logic [9:0] EXP_BIAS = 10'h080;
  localparam logic [9:0] EXP_WRAP = 10'h100;
  localparam logic [7:0] EXP_ZERO = 8'h00;
  // Copy-flags instruction code (octal 170000)
  localparam logic [15:0] COPY_FLAGS_CODE = 16'hf000;
  // Status word bit positions
  localparam int CHOP_BIT   = 5;
  // Exception cause codes
  localparam logic [3:0] CAUSE_NONE  = 4'h0;
  localparam logic [3:0] CAUSE_OVF   = 4'h8;
  localparam logic [3:0] CAUSE_UNF   = 4'ha;
  localparam logic [3:0] CAUSE_UNDEF = 4'hc;
  // Flag reset value {n, z, v, c}
  localparam logic [3:0] FLAGS_RST = 4'h0;
endpackage

// [hw/fpad_round.sv]
// Chop or round of a guarded significand to the selected precision.
// Input is normalised with the hidden bit at MSB; purely combinational.
`timescale 1ns/100ps
module fpad_round
#(
  parameter int MANT_W  = 56,
  parameter int GUARD_W = 2
)
(
  // Guarded significand and mode
  input  wire logic [MANT_W+GUARD_W-1:0] mant_i,
  input  wire logic                      dbl_i,
  input  wire logic                      chop_i,
  // Shaped significand and carry-out of rounding
  output logic      [MANT_W-1:0]         mant_o,
  output logic                           carry_o
);
  localparam int SGL_KEEP = 24;
  logic [MANT_W:0]        sum;
  logic [MANT_W-1:0]      kept;
  logic [MANT_W-1:0]      lsb;
  logic                   rbit;

  always_comb
  begin
    // Single precision keeps the top 24 bits; rounding bit is the next one
    if (dbl_i)
    begin
      kept = mant_i[MANT_W+GUARD_W-1:GUARD_W];
      rbit = mant_i[GUARD_W-1];
      lsb  = {{(MANT_W-1){1'b0}}, 1'b1};
    end
    else
    begin
      kept = {mant_i[MANT_W+GUARD_W-1:MANT_W+GUARD_W-SGL_KEEP], {(MANT_W-SGL_KEEP){1'b0}}};
      rbit = mant_i[MANT_W+GUARD_W-SGL_KEEP-1];
      lsb  = {{(SGL_KEEP-1){1'b0}}, 1'b1, {(MANT_W-SGL_KEEP){1'b0}}};
    end
    // Chop drops the tail; round adds one LSB when the rounding bit is set
    if (!chop_i && rbit)
      sum = {1'b0, kept} + {1'b0, lsb};
    else
      sum = {1'b0, kept};
    carry_o = sum[MANT_W];
    mant_o  = carry_o ? sum[MANT_W:1] : sum[MANT_W-1:0];
  end
endmodule

// [hw/fpad_align.sv]
// Exponent compare and significand alignment for the add path.
// Keeps two guard bits plus a sticky bit; purely combinational.
`timescale 1ns/100ps
module fpad_align
#(
  parameter int MANT_W  = 56,
  parameter int GUARD_W = 2
)
(
  // Operand exponents and significands (hidden bit included)
  input  wire logic [7:0]                 exp_a_i,
  input  wire logic [MANT_W-1:0]          mant_a_i,
  input  wire logic [7:0]                 exp_b_i,
  input  wire logic [MANT_W-1:0]          mant_b_i,
  // Larger operand first; smaller shifted right with sticky
  output logic                            swap_o,
  output logic      [7:0]                 exp_big_o,
  output logic      [MANT_W+GUARD_W:0]    big_o,
  output logic      [MANT_W+GUARD_W:0]    small_o
);
  localparam int EXT_W = MANT_W + GUARD_W + 1;
  logic [7:0]       diff;
  logic [EXT_W-1:0] raw;
  logic [EXT_W-1:0] mask;

  always_comb
  begin
    swap_o    = (exp_b_i > exp_a_i) || ((exp_b_i == exp_a_i) && (mant_b_i > mant_a_i));
    exp_big_o = swap_o ? exp_b_i : exp_a_i;
    diff      = swap_o ? (exp_b_i - exp_a_i) : (exp_a_i - exp_b_i);
    big_o     = {(swap_o ? mant_b_i : mant_a_i), {(GUARD_W+1){1'b0}}};
    raw       = {(swap_o ? mant_a_i : mant_b_i), {(GUARD_W+1){1'b0}}};
    mask      = ~({EXT_W{1'b1}} << diff);
    if (diff >= 8'(EXT_W))
    begin
      small_o = {{(EXT_W-1){1'b0}}, |raw};
    end
    else
    begin
      small_o = (raw >> diff) | {{(EXT_W-1){1'b0}}, |(raw & mask)};
    end
  end
endmodule

// [hw/fpad_unit.sv]
// Floating abs/add/copy-flags datapath slice with flags and trap signalling.
// Processor holds operands stable from start until done or trap.
`timescale 1ns/100ps
module fpad_unit
(
  // Clock and reset
  input  wire logic                  CLOCK_I,
  input  wire logic                  RESET_I,
  // Instruction issue
  input  wire logic                  START_I,
  input  wire logic [1:0]            OP_I,
  input  wire logic [15:0]           INSTR_I,
  input  wire logic [63:0]           SRC_I,
  input  wire logic [63:0]           TARGET_I,
  // Mode and trap enables
  input  wire logic                  DOUBLE_PRECISION_SELECT_I,
  input  wire logic                  LONG_INTEGER_SELECT_I,
  input  wire logic                  CHOP_SELECT_I,
  input  wire logic                  UNDERFLOW_TRAP_ENABLE_I,
  input  wire logic                  OVERFLOW_TRAP_ENABLE_I,
  input  wire logic                  UNDEFINED_VALUE_TRAP_ENABLE_I,
  // Completion and result
  output logic                       DONE_O,
  output logic                       WRITE_O,
  output logic [63:0]                RESULT_O,
  output logic                       TRAP_O,
  output logic [3:0]                 EXCEPTION_CAUSE_CODE_O,
  output logic                       LONG_INTEGER_O,
  // Floating flags and processor condition codes
  output logic                       FLOAT_CARRY_FLAG_O,
  output logic                       FLOAT_OVERFLOW_FLAG_O,
  output logic                       FLOAT_ZERO_FLAG_O,
  output logic                       FLOAT_NEGATIVE_FLAG_O,
  output logic                       CC_LOAD_O,
  output logic [3:0]                 CC_O
);
  localparam int MW = fpad_pkg::MANT_W;
  localparam int GW = fpad_pkg::GUARD_W;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } fpad_state_t;

  fpad_state_t      state_q, state_d;
  logic [3:0]       flags_q, flags_d;        // {n, z, v, c}
  logic [3:0]       cause_q, cause_d;
  logic [63:0]      result_q, result_d;
  logic             done_q, done_d;
  logic             write_q, write_d;
  logic             trap_q, trap_d;
  logic             cc_load_q, cc_load_d;
  logic [3:0]       cc_q, cc_d;

  // Operand field extraction shared by both operands
  function automatic logic is_neg_zero(input logic [63:0] w);
    is_neg_zero = w[fpad_pkg::SIGN_POS] && (w[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB] == 8'h00);
  endfunction

  function automatic logic [MW-1:0] mant_of(input logic [63:0] w, input logic dbl);
    logic [fpad_pkg::FRAC_W-1:0] f;
    f = w[fpad_pkg::FRAC_W-1:0];
    if (!dbl)
      f = {f[fpad_pkg::FRAC_W-1:fpad_pkg::FRAC_W-fpad_pkg::SGL_FRAC_W],
           {(fpad_pkg::FRAC_W-fpad_pkg::SGL_FRAC_W){1'b0}}};
    mant_of = (w[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB] == 8'h00) ? '0 : {1'b1, f};
  endfunction

  // Add datapath
  logic                 dbl;
  logic [7:0]           exp_s, exp_t;
  logic [MW-1:0]        mant_s, mant_t;
  logic                 sign_s, sign_t;
  logic                 swap;
  logic [7:0]           exp_big;
  logic [MW+GW:0]       big, lesser;
  logic [MW+GW+1:0]     raw_sum;
  logic [MW+GW+1:0]     norm;
  logic [9:0]           true_exp;
  logic [MW-1:0]        shaped;
  logic                 rcarry;
  logic                 sum_sign;
  logic                 sum_zero;
  logic                 add_ovf, add_unf;
  logic [9:0]           fin_exp;
  logic [63:0]          add_word;
  int                   lead;

  assign dbl    = DOUBLE_PRECISION_SELECT_I;
  assign exp_s  = SRC_I[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB];
  assign exp_t  = TARGET_I[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB];
  assign sign_s = SRC_I[fpad_pkg::SIGN_POS];
  assign sign_t = TARGET_I[fpad_pkg::SIGN_POS];
  assign mant_s = mant_of(SRC_I, dbl);
  assign mant_t = mant_of(TARGET_I, dbl);

  fpad_align
  #(
    .MANT_W  (MW),
    .GUARD_W (GW)
  )
  u_align
  (
    .exp_a_i   (exp_t),
    .mant_a_i  (mant_t),
    .exp_b_i   (exp_s),
    .mant_b_i  (mant_s),
    .swap_o    (swap),
    .exp_big_o (exp_big),
    .big_o     (big),
    .small_o   (lesser)
  );

  // Add or subtract magnitudes, then normalise; sticky keeps cancellation exact
  always_comb
  begin
    sum_sign = swap ? sign_s : sign_t;
    if (sign_s == sign_t)
      raw_sum = {1'b0, big} + {1'b0, lesser};
    else
      raw_sum = {1'b0, big} - {1'b0, lesser};
    lead = 0;
    for (int i = 0; i <= MW+GW+1; i++)
      if (raw_sum[i])
        lead = i;
    sum_zero = (raw_sum == '0);
    norm     = raw_sum << (MW+GW+1-lead);
    true_exp = {2'b00, exp_big} + 10'(lead) - 10'(MW+GW);
  end

  fpad_round
  #(
    .MANT_W  (MW),
    .GUARD_W (GW)
  )
  u_round
  (
    .mant_i  ({norm[MW+GW+1:GW+1], |norm[GW:0]}),
    .dbl_i   (dbl),
    .chop_i  (CHOP_SELECT_I),
    .mant_o  (shaped),
    .carry_o (rcarry)
  );

  // Range check and wrapped exponent for trapped results
  always_comb
  begin
    fin_exp = true_exp + {9'h000, rcarry};
    add_ovf = !sum_zero && !fin_exp[9] && (fin_exp > 10'h0ff);
    add_unf = !sum_zero && (fin_exp[9] || (fin_exp == 10'h000));
    add_word = '0;
    add_word[fpad_pkg::SIGN_POS] = sum_sign;
    // Low eight bits only: overflow reads 400 octal low, underflow 400 high
    add_word[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB] = fin_exp[7:0];
    add_word[fpad_pkg::FRAC_W-1:0] = shaped[MW-2:0];
    if (sum_zero)
      add_word = '0;
  end

  // Control and result sequencing
  always_comb
  begin
    state_d   = state_q;
    flags_d   = flags_q;
    cause_d   = cause_q;
    result_d  = result_q;
    done_d    = 1'b0;
    write_d   = 1'b0;
    trap_d    = 1'b0;
    cc_load_d = 1'b0;
    cc_d      = cc_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (START_I)
          state_d = ST_EXEC;
      end
      ST_EXEC:
      begin
        state_d = ST_DONE;
        done_d  = 1'b1;
        unique case (fpad_pkg::fpad_op_t'(OP_I))
          fpad_pkg::OP_ABS:
          begin
            write_d  = 1'b1;
            result_d = TARGET_I;
            result_d[fpad_pkg::SIGN_POS] = 1'b0;
            if (exp_t == fpad_pkg::EXP_ZERO)
              result_d = '0;
            if (!dbl)
              result_d[fpad_pkg::FRAC_W-fpad_pkg::SGL_FRAC_W-1:0] = '0;
            flags_d = {1'b0, (exp_t == fpad_pkg::EXP_ZERO), 2'b00};
            if (UNDEFINED_VALUE_TRAP_ENABLE_I && is_neg_zero(TARGET_I))
            begin
              trap_d  = 1'b1;
              cause_d = fpad_pkg::CAUSE_UNDEF;
            end
          end
          fpad_pkg::OP_ADD:
          begin
            if (UNDEFINED_VALUE_TRAP_ENABLE_I && is_neg_zero(SRC_I))
            begin
              trap_d  = 1'b1;
              cause_d = fpad_pkg::CAUSE_UNDEF;
            end
            else
            begin
              write_d  = 1'b1;
              result_d = add_word;
              if ((add_ovf && !OVERFLOW_TRAP_ENABLE_I) || (add_unf && !UNDERFLOW_TRAP_ENABLE_I))
                result_d = '0;
              if (add_ovf && OVERFLOW_TRAP_ENABLE_I)
              begin
                trap_d  = 1'b1;
                cause_d = fpad_pkg::CAUSE_OVF;
              end
              if (add_unf && UNDERFLOW_TRAP_ENABLE_I)
              begin
                trap_d  = 1'b1;
                cause_d = fpad_pkg::CAUSE_UNF;
              end
              flags_d[0] = 1'b0;
              flags_d[1] = add_ovf;
              flags_d[2] = (result_d[fpad_pkg::EXP_MSB:fpad_pkg::EXP_LSB] == 8'h00);
              flags_d[3] = result_d[fpad_pkg::SIGN_POS];
            end
          end
          fpad_pkg::OP_COPY:
          begin
            if (INSTR_I == fpad_pkg::COPY_FLAGS_CODE)
            begin
              cc_load_d = 1'b1;
              cc_d      = flags_q;
            end
          end
          default:
          begin
            done_d = 1'b1;
          end
        endcase
      end
      ST_DONE:
      begin
        if (!START_I)
          state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      state_q   <= ST_IDLE;
      flags_q   <= fpad_pkg::FLAGS_RST;
      cause_q   <= fpad_pkg::CAUSE_NONE;
      result_q  <= '0;
      done_q    <= 1'b0;
      write_q   <= 1'b0;
      trap_q    <= 1'b0;
      cc_load_q <= 1'b0;
      cc_q      <= 4'h0;
    end
    else
    begin
      state_q   <= state_d;
      flags_q   <= flags_d;
      cause_q   <= cause_d;
      result_q  <= result_d;
      done_q    <= done_d;
      write_q   <= write_d;
      trap_q    <= trap_d;
      cc_load_q <= cc_load_d;
      cc_q      <= cc_d;
    end
  end

  assign DONE_O                 = done_q;
  assign WRITE_O                = write_q;
  assign RESULT_O               = result_q;
  assign TRAP_O                 = trap_q;
  assign EXCEPTION_CAUSE_CODE_O = cause_q;
  assign LONG_INTEGER_O         = LONG_INTEGER_SELECT_I;
  assign FLOAT_CARRY_FLAG_O     = flags_q[0];
  assign FLOAT_OVERFLOW_FLAG_O  = flags_q[1];
  assign FLOAT_ZERO_FLAG_O      = flags_q[2];
  assign FLOAT_NEGATIVE_FLAG_O  = flags_q[3];
  assign CC_LOAD_O              = cc_load_q;
  assign CC_O                   = cc_q;
endmodule

// [tb/fpad_unit_assertions.sv]
// Concurrent checks on the ports of the abs/add/flag-copy slice.
// Bound into fpad_unit; one clock, synchronous active-high reset.
`timescale 1ns/100ps
module fpad_unit_assertions
(
  // Clock, reset and issue
  input wire logic        CLOCK_I, RESET_I, START_I, OVERFLOW_TRAP_ENABLE_I,
  input wire logic        LONG_INTEGER_SELECT_I,
  input wire logic [1:0]  OP_I,
  input wire logic [15:0] INSTR_I,
  // Completion, flags and codes
  input wire logic        DONE_O, WRITE_O, TRAP_O, CC_LOAD_O, LONG_INTEGER_O,
  input wire logic        FLOAT_CARRY_FLAG_O, FLOAT_OVERFLOW_FLAG_O,
  input wire logic        FLOAT_ZERO_FLAG_O, FLOAT_NEGATIVE_FLAG_O,
  input wire logic [63:0] RESULT_O,
  input wire logic [3:0]  EXCEPTION_CAUSE_CODE_O, CC_O
);
  logic [3:0] flags;

  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  assign flags = {FLOAT_NEGATIVE_FLAG_O, FLOAT_ZERO_FLAG_O, FLOAT_OVERFLOW_FLAG_O,
                  FLOAT_CARRY_FLAG_O};

  sequence issue_s;
    $rose(START_I);
  endsequence

  sequence answer_s;
    !DONE_O ##[1:2] DONE_O ##1 !DONE_O;
  endsequence

  answer_time_a: assert property (issue_s |=> answer_s)
    else $error("completion late or not a pulse");
  pulse_qual_a: assert property ((WRITE_O || TRAP_O || CC_LOAD_O) |-> DONE_O)
    else $error("result pulse without completion");
  abs_result_a: assert property (DONE_O && OP_I == fpad_pkg::OP_ABS |-> WRITE_O &&
    !RESULT_O[63] && (RESULT_O[62:55] != 8'h00 || RESULT_O == 64'h0))
    else $error("abs result not a magnitude");
  abs_flags_a: assert property (DONE_O && OP_I == fpad_pkg::OP_ABS |->
    flags == {1'b0, RESULT_O == 64'h0, 2'h0})
    else $error("abs flags wrong");
  add_flags_a: assert property (DONE_O && WRITE_O && !TRAP_O && OP_I == fpad_pkg::OP_ADD |->
    !FLOAT_CARRY_FLAG_O && flags[3:2] == {RESULT_O[63], RESULT_O == 64'h0})
    else $error("add flags wrong");
  ovf_zero_a: assert property (DONE_O && OP_I == fpad_pkg::OP_ADD && FLOAT_OVERFLOW_FLAG_O &&
    !OVERFLOW_TRAP_ENABLE_I && (WRITE_O || !TRAP_O) |-> WRITE_O && !TRAP_O && RESULT_O == 64'h0)
    else $error("untrapped overflow not zero");
  ovf_cause_a: assert property (DONE_O && TRAP_O && WRITE_O && FLOAT_OVERFLOW_FLAG_O |->
    EXCEPTION_CAUSE_CODE_O == fpad_pkg::CAUSE_OVF)
    else $error("overflow trap cause wrong");
  no_negzero_a: assert property (DONE_O && WRITE_O && !TRAP_O |->
    !(RESULT_O[63] && RESULT_O[62:55] == 8'h00))
    else $error("negative zero stored without trap");
  pretrap_hold_a: assert property (DONE_O && TRAP_O && !WRITE_O |->
    $stable(flags) && $stable(RESULT_O))
    else $error("early trap changed state");
  copy_cc_a: assert property (CC_LOAD_O |-> OP_I == fpad_pkg::OP_COPY &&
    INSTR_I == fpad_pkg::COPY_FLAGS_CODE && CC_O == flags)
    else $error("condition code copy wrong");
  long_pass_a: assert property (LONG_INTEGER_O == LONG_INTEGER_SELECT_I)
    else $error("long select not passed");
endmodule

bind fpad_unit fpad_unit_assertions fpad_unit_assertions_inst (.*);

// [tb/fpad_host.sv]
// Processor model: issues one operation at a time, loads condition codes.
// Drives on the falling edge; the bench timeout bounds every wait.
`timescale 1ns/100ps
module fpad_host
(
  // Completion from the unit
  input  wire logic        CLOCK_I, DONE_O, WRITE_O, TRAP_O, CC_LOAD_O,
  input  wire logic [3:0]  CC_O,
  // Issue and modes
  output logic             START_I, DOUBLE_PRECISION_SELECT_I, LONG_INTEGER_SELECT_I,
  output logic             CHOP_SELECT_I, UNDERFLOW_TRAP_ENABLE_I, OVERFLOW_TRAP_ENABLE_I,
  output logic             UNDEFINED_VALUE_TRAP_ENABLE_I,
  output logic [1:0]       OP_I,
  output logic [15:0]      INSTR_I,
  output logic [63:0]      SRC_I, TARGET_I
);
  logic [3:0] proc_cc = 4'h0;
  logic       wr, tr, ccl, seen;

  initial
  begin
    {START_I, OP_I, INSTR_I, SRC_I, TARGET_I} = '0;
    {DOUBLE_PRECISION_SELECT_I, LONG_INTEGER_SELECT_I, CHOP_SELECT_I} = 3'h0;
    {UNDERFLOW_TRAP_ENABLE_I, OVERFLOW_TRAP_ENABLE_I, UNDEFINED_VALUE_TRAP_ENABLE_I} = 3'h0;
  end

  // Processor codes take the copy
  always @(posedge CLOCK_I)
    if (CC_LOAD_O)
      proc_cc <= CC_O;

  task automatic issue(input logic [1:0] op, input logic [15:0] ins, input logic [63:0] src,
                       input logic [63:0] tgt, input logic [5:0] mode);
    @(negedge CLOCK_I);
    {DOUBLE_PRECISION_SELECT_I, LONG_INTEGER_SELECT_I, CHOP_SELECT_I, UNDERFLOW_TRAP_ENABLE_I,
     OVERFLOW_TRAP_ENABLE_I, UNDEFINED_VALUE_TRAP_ENABLE_I} = mode;
    {OP_I, INSTR_I, SRC_I, TARGET_I} = {op, ins, src, tgt};
    START_I = 1'b1;
    seen = 1'b0;
    while (!seen)
    begin
      @(posedge CLOCK_I);
      #1;
      seen = DONE_O;
    end
    {wr, tr, ccl} = {WRITE_O, TRAP_O, CC_LOAD_O};
    repeat (2) @(negedge CLOCK_I);
    START_I = 1'b0;
    // Released operands lose the old value
    {SRC_I, TARGET_I} = ~{SRC_I, TARGET_I};
  endtask
endmodule

// [tb/float_abs_add_flag_copy_tb.sv]
// Self-checking bench for the abs/add/flag-copy slice.
// Host model issues operations; bench compares outputs after completion.
`timescale 1ns/100ps
module float_abs_add_flag_copy_tb;
  localparam logic [1:0]  abs_op = fpad_pkg::OP_ABS, add_op = fpad_pkg::OP_ADD;
  localparam logic [1:0]  cpy_op = fpad_pkg::OP_COPY;
  // Modes {double, long, chop, underflow, overflow, undefined}
  localparam logic [5:0]  m_dbl = 6'h20, m_unf = 6'h04, m_ovf = 6'h02, m_udf = 6'h01;
  localparam logic [63:0] one = {1'b0, 8'h81, 55'h0};
  localparam logic [63:0] big = {1'b0, 8'hff, 1'b1, 54'h0};
  localparam logic [63:0] tiny = {1'b0, 8'h01, 55'h0};
  localparam logic [63:0] less = {1'b1, 8'h01, 2'h1, 53'h0};
  logic        CLOCK_I = 1'b0;
  logic        RESET_I = 1'b1;
  logic        START_I, DONE_O, WRITE_O, TRAP_O, CC_LOAD_O, LONG_INTEGER_O;
  logic        DOUBLE_PRECISION_SELECT_I, LONG_INTEGER_SELECT_I, CHOP_SELECT_I;
  logic        UNDERFLOW_TRAP_ENABLE_I, OVERFLOW_TRAP_ENABLE_I, UNDEFINED_VALUE_TRAP_ENABLE_I;
  logic        FLOAT_CARRY_FLAG_O, FLOAT_OVERFLOW_FLAG_O, FLOAT_ZERO_FLAG_O;
  logic        FLOAT_NEGATIVE_FLAG_O;
  logic [1:0]  OP_I;
  logic [15:0] INSTR_I;
  logic [63:0] SRC_I, TARGET_I, RESULT_O;
  logic [3:0]  EXCEPTION_CAUSE_CODE_O, CC_O;
  logic [54:0] lsb;
  int          error_cnt = 0;
  int          checks = 0;
  int          cycles = 0;

  fpad_unit fpad_unit_inst (.*);
  fpad_host fpad_host_inst (.*);

  always #5 CLOCK_I = ~CLOCK_I;

  task automatic test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge CLOCK_I)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Pulses {write, trap, cc load}; flags {n, z, v, c}
  task automatic run(input logic [1:0] op, input logic [15:0] ins, input logic [63:0] src,
                     input logic [63:0] tgt, input logic [5:0] mode, input logic [63:0] res,
                     input logic [2:0] pls, input logic [3:0] flg);
    fpad_host_inst.issue(op, ins, src, tgt, mode);
    chk("result", RESULT_O, res);
    chk("pulses", 64'({fpad_host_inst.wr, fpad_host_inst.tr, fpad_host_inst.ccl}), 64'(pls));
    chk("flags", 64'({FLOAT_NEGATIVE_FLAG_O, FLOAT_ZERO_FLAG_O, FLOAT_OVERFLOW_FLAG_O,
                      FLOAT_CARRY_FLAG_O}), 64'(flg));
  endtask

  initial
  begin
    repeat (5) @(negedge CLOCK_I);
    RESET_I = 1'b0;
    run(abs_op, 16'h0, one, {1'b1, 8'h85, 55'h1234}, m_dbl, {1'b0, 8'h85, 55'h1234},
        3'h4, 4'h0);
    run(abs_op, 16'h0, one, {1'b1, 8'h00, 55'h77}, 6'h0, 64'h0, 3'h4, 4'h4);
    run(abs_op, 16'h0, one, {1'b1, 63'h0}, m_udf, 64'h0, 3'h6, 4'h4);
    chk("cause", 64'(EXCEPTION_CAUSE_CODE_O), 64'(fpad_pkg::CAUSE_UNDEF));
    for (int i = 0; i < 4; i++)
    begin
      lsb = i[1] ? 55'h1 : {23'h1, 32'h0};
      run(add_op, 16'h0, one, {1'b0, 8'h81, lsb}, {i[1], i[0], i[0], 3'h0},
          {1'b0, 8'h82, i[0] ? 55'h0 : lsb}, 3'h4, 4'h0);
      chk("long", 64'(LONG_INTEGER_O), 64'(i[0]));
    end
    run(add_op, 16'h0, one, {1'b1, 8'h81, 55'h0}, 6'h0, 64'h0, 3'h4, 4'h4);
    run(add_op, 16'h0, {1'b1, 8'h82, 55'h0}, one, m_dbl, {1'b1, 8'h81, 55'h0},
        3'h4, 4'h8);
    run(add_op, 16'h0, big, big, m_ovf, {1'b0, 8'h00, 1'b1, 54'h0},
        3'h6, 4'h6);
    chk("ovf flags", 64'({FLOAT_OVERFLOW_FLAG_O, FLOAT_CARRY_FLAG_O}), 64'h2);
    chk("cause", 64'(EXCEPTION_CAUSE_CODE_O), 64'(fpad_pkg::CAUSE_OVF));
    run(add_op, 16'h0, big, big, 6'h0, 64'h0, 3'h4, 4'h6);
    run(cpy_op, 16'hf000, one, one, 6'h0, 64'h0, 3'h1, 4'h6);
    chk("proc cc", 64'(fpad_host_inst.proc_cc), 64'h6);
    run(cpy_op, 16'hf001, one, one, 6'h0, 64'h0, 3'h0, 4'h6);
    run(2'h3, 16'h0, one, one, 6'h0, 64'h0, 3'h0, 4'h6);
    run(add_op, 16'h0, tiny, less, 6'h0, 64'h0, 3'h4, 4'h4);
    run(add_op, 16'h0, tiny, less, m_unf, {1'b1, 8'hff, 55'h0}, 3'h6, 4'h8);
    chk("cause", 64'(EXCEPTION_CAUSE_CODE_O), 64'(fpad_pkg::CAUSE_UNF));
    run(add_op, 16'h0, {1'b1, 63'h0}, one, m_udf, {1'b1, 8'hff, 55'h0}, 3'h2, 4'h8);
    chk("cause", 64'(EXCEPTION_CAUSE_CODE_O), 64'(fpad_pkg::CAUSE_UNDEF));
    test_done();
  end
endmodule
